// ---- bench/bo_brake_top_bench.sv ----
// Self-checking bench for the brake output assignment block
`timescale 1ns/1ps
module bo_brake_top_bench;
    import bo_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and wiring
    // ------------------------------------------------------------
    logic        clk          = 1'b0;
    logic        reset_n      = 1'b0;
    logic [3:0]  stored_code  = 4'h3;
    logic [2:0]  stored_point = 3'h1;
    logic        drive_en     = 1'b0;
    logic        hsel         = 1'b0;
    logic [7:0]  haddr        = 8'h00;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [2:0]  hsize        = 3'h2;
    logic [31:0] hwdata       = 32'h0;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin1;
    logic        pin2;
    logic        relay_on;
    logic [31:0] rd;
    logic [31:0] hrdata_flex;
    logic [31:0] rd_flex;
    logic        flex_pin2;
    logic [3:0]  flex_out;
    logic [3:0]  dut_pts;
    int          failures     = 0;
    int          n_compared   = 0;

    always #5 clk = ~clk;
    assign hready = hreadyout;

    bo_brake_top u_dut (
        .clk(clk), .reset_n(reset_n), .stored_code(stored_code),
        .stored_point(stored_point), .drive_en(drive_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .first_fixed_output(pin1), .second_fixed_output(pin2),
        .flex_point_out(dut_pts)
    );
    // Configurable-point variant with the brake on the second fixed pin
    bo_brake_top #(.FLEX_IO(1'b1), .SECOND_FIX(1'b1)) u_flex (
        .clk(clk), .reset_n(reset_n), .stored_code(stored_code),
        .stored_point(stored_point), .drive_en(drive_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata_flex),
        .hreadyout(), .hresp(),
        .first_fixed_output(), .second_fixed_output(flex_pin2),
        .flex_point_out(flex_out)
    );
    bo_relay_model u_relay (.coil_n(pin1), .energized(relay_on));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        rd_flex = hrdata_flex;
    endtask

    // Register write lands at the data edge, the pin one edge later
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic set_en(input logic v);
        @(posedge clk);
        drive_en <= v;
        settle();
    endtask

    task automatic check_code(input logic [31:0] c, input bo_owner_e o);
        bus(1'b0, BO_ADDR_BRAKE, 32'h0);
        check(rd & 32'h10F, c, "code");
        bus(1'b0, BO_ADDR_STATUS, 32'h0);
        check(rd & 32'h7, 32'(o), "owner");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        check_code(32'h3, BO_OWN_GP);
        check({31'h0, pin1}, 32'h1, "gp pin after reset");
        check({31'h0, relay_on}, 32'h0, "relay after reset");
        check({31'h0, pin2}, 32'h1, "second pin after reset");
        check({31'h0, hresp}, 32'h0, "okay response");
        $display("test reset done");
    endtask

    task automatic test_code(input logic [3:0] c);
        logic en;
        bus(1'b1, BO_ADDR_BRAKE, {28'h0, c});
        check_code({28'h0, c}, BO_OWN_BRAKE);
        for (int i = 0; i < 3; i++) begin
            en = i[0];
            set_en(~en);
            set_en(en);
            check({31'h0, pin1}, {31'h0, (c == 4'h1) ? ~en : en},
                  "brake pin");
            check({31'h0, relay_on}, {31'h0, ~pin1}, "relay");
        end
        bus(1'b0, BO_ADDR_STATUS, 32'h0);
        check(rd & 32'h30, {27'h0, en, 4'h0}, "enable status");
        $display("test code %0d done", c);
    endtask

    task automatic test_gp;
        bus(1'b1, BO_ADDR_BRAKE, 32'h3);
        check_code(32'h3, BO_OWN_GP);
        bus(1'b1, BO_ADDR_OUTGP, 32'h0);
        set_en(1'b1);
        check({31'h0, pin1}, 32'h0, "gp low");
        check({28'h0, dut_pts}, 32'h0, "gp points low");
        set_en(1'b0);
        check({31'h0, pin1}, 32'h0, "gp ignores enable");
        bus(1'b1, BO_ADDR_OUTGP, 32'hF);
        settle();
        check({31'h0, pin1}, 32'h1, "gp high");
        $display("test general purpose done");
    endtask

    task automatic test_refuse;
        bus(1'b1, BO_ADDR_BRAKE, 32'h1);
        bus(1'b1, BO_ADDR_BRAKE, 32'h4);
        bus(1'b1, BO_ADDR_BRAKE, 32'h0);
        check_code(32'h1, BO_OWN_BRAKE);
        bus(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0, "unmapped read");
        $display("test refused codes done");
    endtask

    task automatic test_claim(input logic [2:0] f, input bo_owner_e o);
        bus(1'b1, BO_ADDR_BRAKE, 32'h2);
        bus(1'b1, BO_ADDR_ASSIGN, {29'h0, f});
        check_code(32'h3, o);
        $display("test claim %0d done", f);
    endtask

    // Point 3 is left an input, so the first brake write must be dropped
    task automatic test_flex;
        bus(1'b1, BO_ADDR_DIR, 32'h8);
        bus(1'b1, BO_ADDR_BRAKE, 32'h31);
        bus(1'b0, BO_ADDR_BRAKE, 32'h0);
        check(rd_flex & 32'h17F, 32'h113, "point not output");
        bus(1'b1, BO_ADDR_BRAKE, 32'h41);
        bus(1'b0, BO_ADDR_BRAKE, 32'h0);
        check(rd_flex & 32'h17F, 32'h141, "flex readback");
        set_en(1'b1);
        check({28'h0, flex_out}, 32'h7, "flex point closed");
        set_en(1'b0);
        check({28'h0, flex_out}, 32'hF, "flex point open");
        check({31'h0, flex_pin2}, 32'h1, "flex second fixed");
        $display("test configurable point done");
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        test_reset();
        test_code(4'h1);
        test_code(4'h2);
        test_gp();
        test_refuse();
        test_claim(3'h0, BO_OWN_ALARM);
        test_claim(3'h2, BO_OWN_MOTION);
        test_flex();
        give_verdict();
    end

    // The run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule

// ---- bench/bo_relay_model.sv ----
// Model of the external relay that switches the motor holding brake
`timescale 1ns/1ps
module bo_relay_model (
    // Coil drive from the block, low energizes
    input  wire logic coil_n,
    // Contact state seen by the brake
    output logic      energized
);
    // ------------------------------------------------------------
    // Coil
    // ------------------------------------------------------------
    // Only a firm low pulls the relay in, so an unknown coil reads open
    assign energized = (coil_n === 1'b0);
endmodule

// ---- design/bo_brake_top.sv ----
// Brake output assignment block with AHB-Lite register slave
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module bo_brake_top
    import bo_pkg::*;
#(
    parameter logic FLEX_IO    = 1'b0,
    parameter logic SECOND_FIX = 1'b0
)(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // Stored code restored at reset release
    input  wire logic [3:0]           stored_code,
    input  wire logic [2:0]           stored_point,
    // Drive enable state
    input  wire logic                 drive_en,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Output pins
    output logic                      first_fixed_output,
    output logic                      second_fixed_output,
    output logic [BO_NUM_POINTS-1:0]  flex_point_out
);
    import bo_pkg::*;

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    logic        wr_pend_ff;
    logic        rd_pend_ff;
    logic [7:0]  addr_ff;
    logic [31:0] hrdata_ff;
    logic        load_ff;

    wire take = hsel && hready && htrans[1];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
        end else begin
            wr_pend_ff <= take && hwrite;
            rd_pend_ff <= take && !hwrite;
            addr_ff    <= haddr;
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a[7:2] == b[7:2]);
    endfunction

    wire wr_brake  = wr_pend_ff && hit(addr_ff, BO_ADDR_BRAKE);
    wire wr_assign = wr_pend_ff && hit(addr_ff, BO_ADDR_ASSIGN);
    wire wr_dir    = wr_pend_ff && hit(addr_ff, BO_ADDR_DIR);
    wire wr_gp     = wr_pend_ff && hit(addr_ff, BO_ADDR_OUTGP);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [3:0] code_ff;
    logic [2:0] point_ff;
    logic [3:0] dir_ff;
    logic [3:0] gp_ff;
    logic [3:0] nxt_code;
    logic [2:0] nxt_point;

    wire [3:0]  wcode  = hwdata[BO_CODE_LSB +: 4];
    wire [2:0]  wpoint = hwdata[BO_POINT_LSB +: 3];
    wire        wcode_ok = (wcode == BO_CODE_CLOSE_EN) ||
                           (wcode == BO_CODE_OPEN_EN) ||
                           (wcode == BO_CODE_UNUSED);
    wire        wpt_ok  = (wpoint >= 3'h1) && (wpoint <= 3'h4);
    // With FLEX_IO the point must already be an output; otherwise the write is dropped
    wire        wpt_out = dir_ff[wpoint[1:0] - 2'h1];
    wire        brake_wr_ok = wr_brake && wcode_ok &&
                              (!FLEX_IO || (wpt_ok && wpt_out));
    wire        brake_claim = brake_wr_ok &&
                              (wcode != BO_CODE_UNUSED);
    wire        brake_rel   = brake_wr_ok &&
                              (wcode == BO_CODE_UNUSED);
    wire [2:0]  aown = hwdata[BO_OWNER_LSB +: 3];
    wire        other_claim = wr_assign && (aown <= 3'h4) &&
                              (aown != 3'h1);
    bo_owner_e  owner;
    logic       brake_lost;

    bo_owner_arb u_arb (
        .clk           (clk),
        .reset_n       (reset_n),
        .brake_claim   (brake_claim),
        .brake_release (brake_rel),
        .other_claim   (other_claim),
        .other_owner   (bo_owner_e'(aown)),
        .owner         (owner),
        .brake_lost    (brake_lost)
    );

    assign nxt_code  = load_ff     ? stored_code :
                       brake_wr_ok ? wcode :
                       brake_lost  ? BO_CODE_UNUSED :
                       code_ff;
    assign nxt_point = load_ff ? stored_point :
                       (brake_wr_ok && FLEX_IO) ? wpoint : point_ff;

    // Stored code is loaded once just after reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            load_ff  <= 1'b1;
            code_ff  <= BO_RST_CODE;
            point_ff <= BO_RST_POINT;
            dir_ff   <= BO_RST_DIR;
            gp_ff    <= BO_RST_GP;
        end else begin
            load_ff  <= 1'b0;
            code_ff  <= nxt_code;
            point_ff <= nxt_point;
            dir_ff   <= wr_dir ? hwdata[3:0] : dir_ff;
            gp_ff    <= wr_gp  ? hwdata[3:0] : gp_ff;
        end
    end

    // ------------------------------------------------------------------
    // Output level and pin routing
    // ------------------------------------------------------------------
    logic       brake_level;
    wire        brake_on = (code_ff != BO_CODE_UNUSED);

    bo_level_gen u_lvl (
        .code     (code_ff),
        .drive_en (drive_en),
        .gp_level (1'b1),
        .level    (brake_level)
    );

    logic       fix1_ff;
    logic       fix2_ff;
    logic [3:0] flex_ff;
    wire        fix_lvl = (brake_on && owner == BO_OWN_BRAKE) ?
                          brake_level : gp_ff[0];
    wire        fix1 = SECOND_FIX ? gp_ff[0] : fix_lvl;
    wire        fix2 = SECOND_FIX ? fix_lvl : gp_ff[1];
    logic [3:0] flex_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < BO_NUM_POINTS; gi++) begin : g_pt
            assign flex_nxt[gi] = (FLEX_IO && brake_on &&
                                   point_ff == 3'(gi + 1)) ?
                                  brake_level : gp_ff[gi];
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fix1_ff <= 1'b1;
            fix2_ff <= 1'b1;
            flex_ff <= BO_RST_GP;
        end else begin
            fix1_ff <= fix1;
            fix2_ff <= fix2;
            flex_ff <= flex_nxt;
        end
    end

    assign first_fixed_output  = fix1_ff;
    assign second_fixed_output = fix2_ff;
    assign flex_point_out      = flex_ff;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire [31:0] rd_brake  = {23'h0, FLEX_IO, 1'b0, point_ff,
                             code_ff};
    wire [31:0] rd_status = {26'h0, SECOND_FIX, drive_en, 1'b0, owner};
    wire [7:0]  raddr     = haddr;
    wire [31:0] rd_mux =
        hit(raddr, BO_ADDR_BRAKE)  ? rd_brake :
        hit(raddr, BO_ADDR_DIR)    ? {28'h0, dir_ff} :
        hit(raddr, BO_ADDR_STATUS) ? rd_status :
        hit(raddr, BO_ADDR_OUTGP)  ? {28'h0, gp_ff} :
        32'h0000_0000;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata_ff <= 32'h0000_0000;
        end else begin
            hrdata_ff <= (take && !hwrite) ? rd_mux : hrdata_ff;
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_code1_level: assert property (@(posedge clk) disable iff (!reset_n)
        (!FLEX_IO && !SECOND_FIX && code_ff == BO_CODE_CLOSE_EN &&
         owner == BO_OWN_BRAKE) |=> first_fixed_output ==
         !$past(drive_en))
        else $error("code 1 level wrong");
    a_code2_level: assert property (@(posedge clk) disable iff (!reset_n)
        (!FLEX_IO && !SECOND_FIX && code_ff == BO_CODE_OPEN_EN &&
         owner == BO_OWN_BRAKE) |=> first_fixed_output ==
         $past(drive_en))
        else $error("code 2 level wrong");
    a_code3_free: assert property (@(posedge clk) disable iff (!reset_n)
        (!SECOND_FIX && code_ff == BO_CODE_UNUSED) |=>
        first_fixed_output == $past(gp_ff[0]))
        else $error("code 3 output not free");
    a_lost_code3: assert property (@(posedge clk) disable iff (!reset_n)
        (brake_lost && !load_ff) |=> code_ff == BO_CODE_UNUSED)
        else $error("code not set to 3 on reassignment");
    a_owner_range: assert property (@(posedge clk) disable iff (!reset_n)
        owner inside {BO_OWN_ALARM, BO_OWN_BRAKE, BO_OWN_MOTION,
                      BO_OWN_TACH, BO_OWN_GP})
        else $error("owner out of range");
    a_brake_owns: assert property (@(posedge clk) disable iff (!reset_n)
        (brake_claim && !load_ff) |=> code_ff == $past(wcode) &&
        owner == BO_OWN_BRAKE)
        else $error("brake write did not take ownership");
    a_point_dir: assert property (@(posedge clk) disable iff (!reset_n)
        (FLEX_IO && wr_brake && !wpt_out && !load_ff) |=>
        $stable(point_ff))
        else $error("point taken while not an output");
    a_readback: assert property (@(posedge clk) disable iff (!reset_n)
        (take && !hwrite && hit(haddr, BO_ADDR_BRAKE)) |=>
        hrdata[3:0] == $past(code_ff) && hrdata[6:4] == $past(point_ff))
        else $error("readback mismatch");
    a_reset_load: assert property (@(posedge clk) disable iff (!reset_n)
        load_ff |=> code_ff == $past(stored_code))
        else $error("stored code not restored");

    c_brake_claim: cover property (@(posedge clk) disable iff (!reset_n)
        brake_claim);
    c_brake_lost: cover property (@(posedge clk) disable iff (!reset_n)
        brake_lost);
    c_en_toggle: cover property (@(posedge clk) disable iff (!reset_n)
        brake_on ##1 $changed(drive_en));
endmodule

// ---- design/bo_level_gen.sv ----
// Brake level generator from function code and drive enable
`timescale 1ns/1ps
module bo_level_gen
    import bo_pkg::*;
(
    // Configuration
    input  wire logic [3:0] code,
    input  wire logic       drive_en,
    input  wire logic       gp_level,
    // Level, low means closed
    output logic            level
);
    import bo_pkg::*;

    wire closed = (code == BO_CODE_CLOSE_EN) ?  drive_en :
                  (code == BO_CODE_OPEN_EN)  ? !drive_en :
                  1'b0;
    wire brake  = (code == BO_CODE_CLOSE_EN) ||
                  (code == BO_CODE_OPEN_EN);

    // Closed is active low on the pin
    assign level = brake ? !closed : gp_level;
endmodule

// ---- design/bo_owner_arb.sv ----
// Ownership arbiter: one function owns the output at a time
`timescale 1ns/1ps
module bo_owner_arb
    import bo_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Claims
    input  wire logic              brake_claim,
    input  wire logic              brake_release,
    input  wire logic              other_claim,
    input  wire bo_owner_e         other_owner,
    // Result
    output bo_pkg::bo_owner_e      owner,
    output logic                   brake_lost
);
    import bo_pkg::*;

    bo_owner_e owner_ff;
    bo_owner_e nxt_owner;
    wire       brake_held = (owner_ff == BO_OWN_BRAKE);

    // Brake claim wins a same-cycle clash: brake write is newer intent
    assign nxt_owner = brake_claim ? BO_OWN_BRAKE :
                       other_claim ? other_owner :
                       (brake_release && brake_held) ? BO_OWN_GP :
                       owner_ff;
    assign brake_lost = other_claim && !brake_claim && brake_held;
    assign owner      = owner_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            owner_ff <= BO_OWN_GP;
        end else begin
            owner_ff <= nxt_owner;
        end
    end

    a_single_owner: assert property (@(posedge clk) disable iff (!reset_n)
        brake_claim |=> owner_ff == BO_OWN_BRAKE)
        else $error("brake claim did not take the output");
endmodule

// ---- design/bo_pkg.sv ----
// Package of constants and types for the brake output assignment block
package bo_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] BO_ADDR_BRAKE   = 8'h00;
    localparam logic [7:0] BO_ADDR_ASSIGN  = 8'h04;
    localparam logic [7:0] BO_ADDR_DIR     = 8'h08;
    localparam logic [7:0] BO_ADDR_STATUS  = 8'h0C;
    localparam logic [7:0] BO_ADDR_OUTGP   = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BO_CODE_LSB   = 0;
    localparam int BO_POINT_LSB  = 4;
    localparam int BO_FLEX_BIT   = 8;
    localparam int BO_OWNER_LSB  = 0;
    localparam int BO_EN_BIT     = 4;
    localparam int BO_FIXSEL_BIT = 5;

    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] BO_CODE_CLOSE_EN = 4'h1;
    localparam logic [3:0] BO_CODE_OPEN_EN  = 4'h2;
    localparam logic [3:0] BO_CODE_UNUSED   = 4'h3;
    localparam logic [3:0] BO_RST_CODE      = 4'h3;
    localparam logic [2:0] BO_RST_POINT     = 3'h1;
    localparam logic [3:0] BO_RST_DIR       = 4'h0;
    localparam logic [3:0] BO_RST_GP        = 4'hF;
    localparam int         BO_NUM_POINTS    = 4;

    // Owner of the automatic output
    typedef enum logic [2:0] {
        BO_OWN_ALARM,
        BO_OWN_BRAKE,
        BO_OWN_MOTION,
        BO_OWN_TACH,
        BO_OWN_GP
    } bo_owner_e;

endpackage
